// *** verilog/refresh_defs.vh ***
// Purpose: Constants for the refresh controller and interval timer.
// Assumes: 8-bit timer registers, 100 MHz system clock.
// Notes: Status layout: bit7 match flag, bit6 irq enable, bits5..3 clock select.
// Function
// - Refresh logic runs in sleep, stops fully in hardware standby; code freezes the timer, but a refresh cycle under way still finishes.
// - Software standby clears counter, match flag and irq enable; keeps clock select and constant.
// - First match after reset or standby produces no refresh cycle.
// - Match flag is status bit 7, readable for counting intervals.
// - Up to four area-3 chips share one refresh strobe.
// - Refresh strobe asserts in every refresh cycle.
// - Pseudo-static mode uses same constant and clock select for interval.
// - Pseudo-static cycles take same states as dynamic RAM cycles.
// - Area-3 access-state bit set lets wait states stretch refresh cycles.
// - Self-refresh standby drives chip select high, strobe low; exit restores.
// - Pseudo-static standby floats read and write strobes, chip select high.
// - Interval timer needs both memory enables clear.
// - Match flag sets when counter leaves the matching value.
// - Timer standby clears counter, flag and enable; keeps select and constant.
// - Clear during counter write wins; written value discarded.
// - Write during increment wins; increment dropped.
// - Constant write suppresses a simultaneous compare match.
// - Counter counts falling edges; fast-to-slow switch counts once.
// - Bus priority: external master, refresh, DMA, processor.
// - Interrupt request only while enable bit set.
`ifndef REFRESH_DEFS_VH
`define REFRESH_DEFS_VH
`define CSR_FLAG_BIT   7
`define CSR_IEN_BIT    6
`define CSR_CKS_HI     5
`define CSR_CKS_LO     3
`define COUNTER_RESET  8'h00
`define CONSTANT_RESET 8'hff
`define CKS_RESET      3'h0
`define REFRESH_STATES 3'h4
`endif

// *** verilog/clock_source_select.v ***
// Purpose: Prescaler and falling-edge pulse for the refresh counter.
// Assumes: Select 0 halts; 1..7 pick divide by 2,8,32,128,512,2048,4096.
// Notes: A select change that drops the clock level reads as a falling edge.
`timescale 1ns/1ps
`default_nettype none
module clock_source_select
(
  input  wire       clock_i,
  input  wire       reset_i,
  input  wire       run_i,
  input  wire [2:0] select_i,
  output wire       tick_o
);
  reg  [11:0] prescale;
  reg         last_level;
  wire        level;

  // Pick one prescaler bit as the source clock
  function src_bit;
    input [2:0]  s;
    input [11:0] p;
    begin
      case (s)
        3'h1: src_bit = p[0];
        3'h2: src_bit = p[2];
        3'h3: src_bit = p[4];
        3'h4: src_bit = p[6];
        3'h5: src_bit = p[8];
        3'h6: src_bit = p[10];
        3'h7: src_bit = p[11];
        default: src_bit = 1'b0;
      endcase
    end
  endfunction

  assign level = src_bit(select_i, prescale);

  // Free-running prescaler, held in hardware standby
  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      prescale   <= 12'h000;
      last_level <= 1'b0;
    end
    else if (run_i)
    begin
      prescale   <= prescale + 12'h001;
      last_level <= level;
    end
  end

  // Falling edge of the chosen source, including a switch to a low level
  assign tick_o = run_i & last_level & ~level;
endmodule
`default_nettype wire

// *** verilog/refresh_cycle_fsm.v ***
// Purpose: Runs one refresh bus cycle once the arbiter grants it.
// Assumes: Wait requests come from the wait state controller.
// Notes: Same state count for dynamic and pseudo-static memory.
`timescale 1ns/1ps
`default_nettype none
`include "refresh_defs.vh"
module refresh_cycle_fsm
(
  input  wire clock_i,
  input  wire reset_i,
  input  wire start_i,
  input  wire wait_i,
  output reg  strobe_n_o,
  output wire busy_o
);
  localparam IDLE = 1'b0;
  localparam RUN  = 1'b1;
  reg       state;
  reg [2:0] count;

  assign busy_o = state;

  // Fixed-length cycle stretched by wait requests
  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      state      <= IDLE;
      count      <= 3'h0;
      strobe_n_o <= 1'b1;
    end
    else
    begin
      case (state)
        IDLE:
        begin
          if (start_i)
          begin
            state      <= RUN;
            count      <= 3'h1;
            strobe_n_o <= 1'b0;
          end
        end
        RUN:
        begin
          if (wait_i)
            count <= count;
          else if (count == `REFRESH_STATES)
          begin
            state      <= IDLE;
            strobe_n_o <= 1'b1;
          end
          else
            count <= count + 3'h1;
        end
        default: state <= IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** verilog/refresh_controller_interval_timer.v ***
// Purpose: Refresh interval timer, request pacing, self-refresh strobes.
// Assumes: Register writes arrive as one-cycle strobes in their final state.
// Notes: Registers are plain ports; the CPU bus lives outside this block.
`timescale 1ns/1ps
`default_nettype none
`include "refresh_defs.vh"
module refresh_controller_interval_timer
(
  input  wire       clock_i,
  input  wire       reset_i,
  input  wire       sleep_i,
  input  wire       hw_standby_i,
  input  wire       sw_standby_i,
  input  wire       dynamic_ram_enable_i,
  input  wire       pseudo_static_enable_i,
  input  wire       self_refresh_enable_i,
  input  wire       area3_access_states_i,
  input  wire       wait_request_i,
  input  wire       ext_master_request_i,
  input  wire       dma_request_i,
  input  wire       cpu_request_i,
  input  wire       counter_write_i,
  input  wire [7:0] counter_wdata_i,
  input  wire       constant_write_i,
  input  wire [7:0] constant_wdata_i,
  input  wire       status_write_i,
  input  wire [7:0] status_wdata_i,
  input  wire       status_read_i,
  output reg  [7:0] refresh_timer_counter_o,
  output reg  [7:0] refresh_time_constant_o,
  output wire [7:0] refresh_timer_control_status_o,
  output wire       compare_match_interrupt_o,
  output wire       ext_master_grant_o,
  output wire       refresh_grant_o,
  output wire       dma_grant_o,
  output wire       cpu_grant_o,
  output reg        refresh_strobe_n_o,
  output reg        area3_chip_select_n_o,
  output wire       bus_strobe_oe_o
);
  reg       compare_match_flag;
  reg       compare_interrupt_enable;
  reg [2:0] clock_select_field;
  reg       flag_seen;
  reg       skip_first;
  reg       request_pending;
  reg       in_standby;
  reg [7:0] next_counter;
  wire      run;
  wire      tick;
  wire      match;
  wire      memory_on;
  wire      cycle_strobe_n;
  wire      cycle_busy;
  wire      start_cycle;

  // Runs in sleep, frozen in hardware standby
  assign run       = ~hw_standby_i;
  assign memory_on = dynamic_ram_enable_i | pseudo_static_enable_i;

  clock_source_select u_clk
  (
    .clock_i  (clock_i),
    .reset_i  (reset_i),
    .run_i    (run),
    .select_i (clock_select_field),
    .tick_o   (tick)
  );

  // Match fires on the tick leaving the matching value, unless constant written
  assign match = tick & (refresh_timer_counter_o == refresh_time_constant_o)
               & ~constant_write_i;

  // Counter next value with clear, write and increment priorities
  always @*
  begin
    next_counter = refresh_timer_counter_o;
    if (match)
      next_counter = `COUNTER_RESET;
    else if (counter_write_i)
      next_counter = counter_wdata_i;
    else if (tick)
      next_counter = refresh_timer_counter_o + 8'h01;
  end

  // Timer registers, status and standby handling
  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      refresh_timer_counter_o  <= `COUNTER_RESET;
      refresh_time_constant_o  <= `CONSTANT_RESET;
      clock_select_field       <= `CKS_RESET;
      compare_match_flag       <= 1'b0;
      compare_interrupt_enable <= 1'b0;
      flag_seen                <= 1'b0;
      skip_first               <= 1'b1;
      in_standby               <= 1'b0;
    end
    else if (sw_standby_i & run)
    begin
      // Hardware standby has priority: nothing moves while it is held
      refresh_timer_counter_o  <= `COUNTER_RESET;
      compare_match_flag       <= 1'b0;
      compare_interrupt_enable <= 1'b0;
      flag_seen                <= 1'b0;
      skip_first               <= 1'b1;
      in_standby               <= 1'b1;
    end
    else if (run)
    begin
      in_standby              <= 1'b0;
      refresh_timer_counter_o <= next_counter;
      if (constant_write_i)
        refresh_time_constant_o <= constant_wdata_i;
      if (status_read_i)
        flag_seen <= compare_match_flag;
      if (status_write_i)
      begin
        clock_select_field       <= status_wdata_i[`CSR_CKS_HI:`CSR_CKS_LO];
        compare_interrupt_enable <= status_wdata_i[`CSR_IEN_BIT];
      end
      // Set beats clear; clear needs a prior read of one
      if (match)
        compare_match_flag <= 1'b1;
      else if (status_write_i & flag_seen & ~status_wdata_i[`CSR_FLAG_BIT])
      begin
        compare_match_flag <= 1'b0;
        flag_seen          <= 1'b0;
      end
      if (match)
        skip_first <= 1'b0;
    end
  end

  assign refresh_timer_control_status_o = {compare_match_flag, compare_interrupt_enable,
                                           clock_select_field, 3'h7};
  assign compare_match_interrupt_o = compare_match_flag & compare_interrupt_enable;

  // Hold one refresh request until the arbiter serves it
  always @(posedge clock_i)
  begin
    if (reset_i | sw_standby_i | ~memory_on)
      request_pending <= 1'b0;
    else if (match & ~skip_first)
      request_pending <= 1'b1;
    else if (start_cycle)
      request_pending <= 1'b0;
  end

  // Fixed priority arbiter
  assign ext_master_grant_o = ext_master_request_i & ~cycle_busy;
  assign refresh_grant_o    = request_pending & ~ext_master_request_i & ~cycle_busy;
  assign dma_grant_o        = dma_request_i & ~request_pending & ~ext_master_request_i
                            & ~cycle_busy;
  assign cpu_grant_o        = cpu_request_i & ~dma_request_i & ~request_pending
                            & ~ext_master_request_i & ~cycle_busy;
  assign start_cycle        = refresh_grant_o & run;

  refresh_cycle_fsm u_cycle
  (
    .clock_i    (clock_i),
    .reset_i    (reset_i),
    .start_i    (start_cycle),
    .wait_i     (wait_request_i & area3_access_states_i),
    .strobe_n_o (cycle_strobe_n),
    .busy_o     (cycle_busy)
  );

  // Strobe pins: refresh cycles normally, self-refresh levels in pseudo-static standby
  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      refresh_strobe_n_o    <= 1'b1;
      area3_chip_select_n_o <= 1'b1;
    end
    else if (sw_standby_i & pseudo_static_enable_i)
    begin
      area3_chip_select_n_o <= 1'b1;
      refresh_strobe_n_o    <= ~self_refresh_enable_i;
    end
    else
    begin
      area3_chip_select_n_o <= 1'b1;
      refresh_strobe_n_o    <= cycle_strobe_n;
    end
  end

  // Read and write strobes float in pseudo-static standby
  assign bus_strobe_oe_o = ~(sw_standby_i & pseudo_static_enable_i) & ~in_standby;
endmodule
`default_nettype wire

// *** verif/refresh_props.sv ***
// Purpose: Port-level checks of the refresh timer.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to the top module from the bench.
`timescale 1ns/1ps
`default_nettype none
module refresh_props
(
  input wire logic       clock_i, reset_i, hw_standby_i, sw_standby_i,
  input wire logic       pseudo_static_enable_i, self_refresh_enable_i,
  input wire logic       ext_master_request_i, counter_write_i, constant_write_i,
  input wire logic [7:0] counter_wdata_i, refresh_timer_counter_o,
  input wire logic [7:0] refresh_time_constant_o, refresh_timer_control_status_o,
  input wire logic       compare_match_interrupt_o, ext_master_grant_o, refresh_grant_o,
  input wire logic       dma_grant_o, cpu_grant_o, refresh_strobe_n_o,
  input wire logic       area3_chip_select_n_o, bus_strobe_oe_o
);
  // Short views of the registers
  wire [7:0] cnt = refresh_timer_counter_o;
  wire [7:0] con = refresh_time_constant_o;
  wire [7:0] st  = refresh_timer_control_status_o;
  wire       run = !hw_standby_i && !sw_standby_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // Counter sits on the constant, then moves on
  sequence leave_match;
    run && !counter_write_i && !constant_write_i && cnt == con ##1 cnt != $past(cnt);
  endsequence
  // Self-refresh standby held over two edges
  sequence srf_standby;
    (sw_standby_i && pseudo_static_enable_i && self_refresh_enable_i)[*2];
  endsequence
  AST_MATCH_CLEAR: assert property (leave_match |-> cnt == 8'h00 && st[7])
    else $error("no clear or flag after match");
  AST_WRITE_WINS: assert property (run && counter_write_i && cnt != con |=> cnt == $past(counter_wdata_i))
    else $error("counter write lost");
  AST_HW_FREEZE: assert property (hw_standby_i |=> $stable(cnt) && $stable(con) && $stable(st))
    else $error("moved in hardware standby");
  AST_SW_CLEAR: assert property (sw_standby_i && !hw_standby_i |=> cnt == 8'h00 && $stable(con) && $stable(st[5:3]))
    else $error("software standby state wrong");
  AST_IRQ: assert property (compare_match_interrupt_o == (st[7] && st[6]))
    else $error("interrupt not flag and enable");
  AST_PRIORITY: assert property (ext_master_request_i |-> ext_master_grant_o && !refresh_grant_o && !dma_grant_o && !cpu_grant_o)
    else $error("external master not first");
  AST_SELF_REFRESH: assert property (srf_standby |-> area3_chip_select_n_o && !refresh_strobe_n_o)
    else $error("self-refresh strobes wrong");
  AST_FLOAT: assert property (sw_standby_i && pseudo_static_enable_i |-> !bus_strobe_oe_o)
    else $error("strobes driven in standby");
endmodule
`default_nettype wire

// *** verif/dram_partner.sv ***
// Purpose: Behavioural area-3 memory seen by the refresh strobe.
// Assumes: All chips share one refresh strobe.
// Notes: Slow mode asks for two wait states per refresh.
`timescale 1ns/1ps
`default_nettype none
module dram_partner
(
  input  wire logic clock_i,
  input  wire logic refresh_strobe_n_i,
  input  wire logic slow_i,
  output var  logic wait_o,
  output var  int   refreshes,
  output var  int   low_len
);
  int run = 0;
  // Every chip refreshes on each strobe fall; length of each low kept
  always @(posedge clock_i)
  begin
    if (!refresh_strobe_n_i)
    begin
      if (run == 0) refreshes <= refreshes + 1;
      run <= run + 1;
    end
    else
    begin
      if (run != 0) low_len <= run;
      run <= 0;
    end
  end
  // Slow chips hold off the first two refresh states
  always @* wait_o = slow_i && !refresh_strobe_n_i && run < 2;
  initial refreshes = 0;
  initial low_len = 0;
endmodule
`default_nettype wire

// *** verif/refresh_controller_interval_timer_tb_top.sv ***
// Purpose: Self-checking bench for the refresh timer.
// Assumes: 100 MHz clock, inputs changed at the falling edge.
// Notes: Far-side memory is a behavioural model.
`timescale 1ns/1ps
`default_nettype none
`include "refresh_defs.vh"
module refresh_controller_interval_timer_tb_top;
  logic       clock_i, reset_i, sleep, hws, sws, dre, pse, sre, ast, exr, dmr, cpr, slow;
  logic       cw, kw, sw, sr;
  logic [7:0] cd, kd, sd, n0;
  wire  [7:0] cnt, con, st;
  wire        irq, gx, gr, gd, gc, rf_n, cs_n, oe, wt;
  int         refreshes, low_len, r0, mismatches, num_checks;
  refresh_controller_interval_timer refresh_controller_interval_timer_inst (
    .clock_i(clock_i), .reset_i(reset_i), .sleep_i(sleep), .hw_standby_i(hws),
    .sw_standby_i(sws), .dynamic_ram_enable_i(dre), .pseudo_static_enable_i(pse),
    .self_refresh_enable_i(sre), .area3_access_states_i(ast), .wait_request_i(wt),
    .ext_master_request_i(exr), .dma_request_i(dmr), .cpu_request_i(cpr),
    .counter_write_i(cw), .counter_wdata_i(cd), .constant_write_i(kw),
    .constant_wdata_i(kd), .status_write_i(sw), .status_wdata_i(sd), .status_read_i(sr),
    .refresh_timer_counter_o(cnt), .refresh_time_constant_o(con),
    .refresh_timer_control_status_o(st), .compare_match_interrupt_o(irq),
    .ext_master_grant_o(gx), .refresh_grant_o(gr), .dma_grant_o(gd), .cpu_grant_o(gc),
    .refresh_strobe_n_o(rf_n), .area3_chip_select_n_o(cs_n), .bus_strobe_oe_o(oe));
  dram_partner dram_partner_inst (.clock_i(clock_i), .refresh_strobe_n_i(rf_n),
    .slow_i(slow), .wait_o(wt), .refreshes(refreshes), .low_len(low_len));
  // Clock
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task cyc(input int n); repeat (n) @(negedge clock_i); endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One-cycle register write strobe: counter, constant, status
  task wr(input logic [2:0] w, input logic [7:0] d);
    {cw, kw, sw} = w; {cd, kd, sd} = {d, d, d}; cyc(1); {cw, kw, sw} = 3'h0;
  endtask
  task wait_flag; for (int i = 0; i < 600 && st[7] !== 1'b1; i++) cyc(1); endtask
  task clear_flag; sr = 1'b1; cyc(1); sr = 1'b0; wr(3'h1, 8'h08); endtask
  task t_reset;
    chk("counter", 8'h00, cnt);
    chk("constant", 8'hff, con);
    chk("status", 8'h07, st);
  endtask
  task t_timer;
    sleep = 1'b1;
    wr(3'h2, 8'h03); wr(3'h1, 8'h48); wait_flag;
    chk("flag", 8'h01, {7'h0, st[7]});
    chk("cleared counter", 8'h00, cnt);
    chk("irq", 8'h01, {7'h0, irq});
    clear_flag;
    chk("flag cleared", 8'h00, {7'h0, st[7]});
    wait_flag;
    chk("masked irq", 8'h02, {6'h0, st[7], irq});
    wr(3'h2, 8'hf0); wr(3'h4, 8'h01);
    chk("written counter", 8'h01, cnt);
    n0 = cnt; hws = 1'b1; cyc(5); hws = 1'b0;
    chk("frozen counter", n0, cnt);
    // Align to a tick so the divide-by-2 source is high at the switch edge
    n0 = cnt;
    for (int i = 0; i < 8 && cnt == n0; i++) cyc(1);
    n0 = cnt; wr(3'h1, 8'h00); cyc(2);
    chk("switch count", n0 + 8'h01, cnt);
  endtask
  task t_refresh;
    clear_flag; wr(3'h2, 8'h03); dre = 1'b1;
    sws = 1'b1; cyc(2); sws = 1'b0;
    chk("standby counter", 8'h00, cnt);
    chk("standby select", 8'h01, {5'h0, st[5:3]});
    r0 = refreshes; wait_flag; cyc(4);
    chk("first skipped", 8'h00, 8'(refreshes - r0));
    cyc(20);
    chk("refresh issued", 8'h01, {7'h0, refreshes > r0});
    chk("refresh length", {5'h0, `REFRESH_STATES}, low_len[7:0]);
    dre = 1'b0; pse = 1'b1; ast = 1'b1; slow = 1'b1; r0 = refreshes; cyc(40);
    chk("pseudo refresh", 8'h01, {7'h0, refreshes > r0});
    chk("stretched", 8'h01, {7'h0, low_len > 4});
  endtask
  task t_standby;
    slow = 1'b0; wr(3'h2, 8'hff); cyc(8); sre = 1'b1; sws = 1'b1; cyc(3);
    chk("self standby pins", 8'h04, {5'h0, cs_n, rf_n, oe});
    sws = 1'b0; cyc(3);
    chk("strobe after exit", 8'h01, {7'h0, rf_n});
    sre = 1'b0; sws = 1'b1; cyc(3);
    chk("plain standby pins", 8'h06, {5'h0, cs_n, rf_n, oe});
    sws = 1'b0; pse = 1'b0;
  endtask
  task t_prio;
    for (int i = 0; i < 3; i++)
    begin
      {exr, dmr, cpr} = 3'h7 >> i; cyc(1);
      chk("grants", 8'h08 >> (i ? i + 1 : 0), {4'h0, gx, gr, gd, gc});
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {reset_i, sleep, hws, sws, dre, pse, sre, ast, exr, dmr, cpr, slow} = 12'h800;
    {cw, kw, sw, sr, cd, kd, sd} = 28'h0;
    cyc(3); reset_i = 1'b0;
    t_reset; t_timer; t_refresh; t_standby; t_prio;
    summarize;
  end
  // Watchdog
  initial
  begin
    #60000; mismatches++; summarize;
  end
endmodule
bind refresh_controller_interval_timer refresh_props refresh_props_inst (.clock_i, .reset_i,
  .hw_standby_i, .sw_standby_i, .pseudo_static_enable_i, .self_refresh_enable_i,
  .ext_master_request_i, .counter_write_i, .constant_write_i, .counter_wdata_i,
  .refresh_timer_counter_o, .refresh_time_constant_o, .refresh_timer_control_status_o,
  .compare_match_interrupt_o, .ext_master_grant_o, .refresh_grant_o, .dma_grant_o,
  .cpu_grant_o, .refresh_strobe_n_o, .area3_chip_select_n_o, .bus_strobe_oe_o);
`default_nettype wire
